// [rtl/tcp_fifo.sv]
// Synchronous word FIFO with valid/ready on both sides.
// Assumes a single clock; flags are registered.
`timescale 1ns/100ps
module tcp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // Occupancy after this cycle
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rd_ptr];

  // Storage writes
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and registered flags
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end
endmodule : tcp_fifo

// [rtl/tcp_parser.sv]
// Transmit command word parser: takes host words through a FIFO,
// strips command words, offsets and end padding, checks packet length.
// Assumes host words come from logic on ref_clk and the MAC side
// obeys valid/ready.
// Words are trusted to arrive in stream order; no resync after an error.
`timescale 1ns/100ps

// How it works
// [RULE1] Command A bits 20:16 give start offset
// [RULE2] Command A bit 13 marks opening segment
// [RULE3] Command A bit 12 marks closing segment
// [RULE4] Buffer size and alignment give padding words
// [RULE5] Summed segment sizes checked against length
// [RULE6] Command B tag copied out for status
// [RULE7] Command B bit 13 suppresses appended FCS
// [RULE8] Bit 12 stops padding, forces FCS on
// [RULE9] Command B bits 10:0 packet byte count
// [RULE10] Data follows the two command words
// [RULE11] Low offset bits choose first byte lane
// [RULE12] Upper offset bits skip whole leading words
// [RULE13] Unused trailing bytes never forwarded
// [RULE14] Host end padding dropped automatically
// [RULE15] Host writes zeros in reserved bits
// [RULE16] Alignment code 00/01/10, 11 reserved
// [RULE17] Command B must match across segments
// [RULE18] Missing or early opening segment flagged
module tcp_parser (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic host_valid,
  input wire logic [31:0] host_data,
  output logic host_ready,
  output logic tx_valid,
  output logic [31:0] tx_data,
  output logic [3:0] tx_byte_en,
  output logic tx_first,
  output logic tx_last,
  input wire logic tx_ready,
  output logic [15:0] pkt_tag,
  output logic crc_append,
  output logic pad_disable,
  output logic transmit_error_flag,
  input wire logic error_clear
);
  // FIFO side signals
  // The FIFO head is read in place and popped only when used
  logic fifo_in_ready;
  logic fifo_valid;
  logic [tcp_pkg::WORD_W-1:0] word;
  logic fifo_pop;

  // Parser state
  // Fields of the current buffer live here until its last word
  tcp_pkg::tcp_state_t state;
  tcp_pkg::tcp_state_t next_state;
  logic [tcp_pkg::CNT_W-1:0] cnt;
  logic [tcp_pkg::CNT_W-1:0] next_cnt;
  logic [4:0] start_off;
  logic [1:0] align_code;
  logic seg_first;
  logic seg_last;
  logic [tcp_pkg::SIZE_W-1:0] buf_size;
  logic [tcp_pkg::WORD_W-1:0] saved_b;
  logic [tcp_pkg::SUM_W-1:0] byte_sum;
  logic in_packet;
  logic first_pending;
  logic word_first;
  logic [2:0] pad_n;

  // Host words land in the FIFO before parsing
  // It absorbs MAC stalls so the host sees back-pressure late
  tcp_fifo #(
    .WIDTH(tcp_pkg::WORD_W),
    .DEPTH(tcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(host_valid),
    .in_data(host_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_valid),
    .out_data(word),
    .out_ready(fifo_pop)
  );

  // Field decode of the word at the FIFO head; the state says which
  // command word it is, so both layouts are decoded side by side
  wire [4:0] w_off = word[tcp_pkg::A_OFF_HI:tcp_pkg::A_OFF_LO]; // RULE1
  wire [1:0] w_align = word[tcp_pkg::A_ALIGN_HI:tcp_pkg::A_ALIGN_LO];
  wire w_first = word[tcp_pkg::A_FIRST_BIT]; // RULE2
  wire w_last = word[tcp_pkg::A_LAST_BIT]; // RULE3
  wire [tcp_pkg::SIZE_W-1:0] w_size = word[tcp_pkg::SIZE_HI:0]; // RULE4 RULE9

  // Second command word fields
  wire [15:0] w_tag = word[tcp_pkg::B_TAG_HI:tcp_pkg::B_TAG_LO]; // RULE6
  wire w_crc_off = word[tcp_pkg::B_CRC_OFF_BIT];
  wire w_pad_off = word[tcp_pkg::B_PAD_OFF_BIT];

  // Word counts derived from the stored first command word; the lane
  // offset widens the byte span, rounding up gives whole data words
  wire [1:0] lane_lo = start_off[1:0]; // RULE11
  wire [2:0] skip_n = start_off[4:2]; // RULE12
  wire [tcp_pkg::SUM_W-1:0] span = tcp_pkg::SUM_W'(lane_lo) + tcp_pkg::SUM_W'(buf_size);
  wire [tcp_pkg::SUM_W-1:0] span_up = span + tcp_pkg::BYTE_ROUND;
  wire [tcp_pkg::CNT_W-1:0] data_n = span_up[tcp_pkg::SUM_W-1:2];

  // Lane of the last valid byte in the final data word
  wire [tcp_pkg::SUM_W-1:0] span_end = span - 1'b1;
  wire [1:0] lane_hi = span_end[1:0]; // RULE13

  // Alignment mask in words
  // Reserved code falls back to no padding and is flagged below
  wire [2:0] align_mask = (align_code == tcp_pkg::ALIGN_32) ? tcp_pkg::ALIGN_32_MASK :
                          (align_code == tcp_pkg::ALIGN_16) ? tcp_pkg::ALIGN_16_MASK :
                          tcp_pkg::ALIGN_4_MASK; // RULE16

  // Padding words bring the buffer to the alignment boundary
  // The two command words count, so the whole buffer is aligned
  wire [12:0] buf_words = tcp_pkg::CMD_WORDS + 13'(skip_n) + 13'(data_n); // RULE10
  wire [12:0] buf_neg = 13'h0000 - buf_words;
  wire [2:0] pad_calc = buf_neg[2:0] & align_mask; // RULE4 RULE14

  // Byte enables for the current data word
  // A one-word buffer gets both the low and the high mask
  wire [3:0] mask_lo = tcp_pkg::BE_ALL << lane_lo; // RULE11
  wire [3:0] mask_hi = tcp_pkg::BE_ALL >> (tcp_pkg::LANE_TOP - lane_hi); // RULE13
  wire last_word = (cnt == tcp_pkg::CNT_W'(1));
  wire [3:0] word_be = (word_first ? mask_lo : tcp_pkg::BE_ALL) &
                       (last_word ? mask_hi : tcp_pkg::BE_ALL);

  // Output stage can take a word
  // Only data words wait for it; command, skip and pad words never stall
  wire out_free = ~tx_valid | tx_ready;
  assign fifo_pop = fifo_valid & ((state != tcp_pkg::ST_DATA) | out_free);
  wire take_a = fifo_pop & (state == tcp_pkg::ST_CMD_A);
  wire take_b = fifo_pop & (state == tcp_pkg::ST_CMD_B);
  wire take_d = fifo_pop & (state == tcp_pkg::ST_DATA);

  // Running byte sum including this segment
  // An opening segment restarts the sum, whatever came before
  wire [tcp_pkg::SUM_W-1:0] sum_base = seg_first ? '0 : byte_sum;
  wire [tcp_pkg::SUM_W-1:0] sum_new = sum_base + tcp_pkg::SUM_W'(buf_size); // RULE5

  // Error conditions checked when the second command word arrives
  // The first command word is already captured by then
  wire err_len = seg_last & (sum_new != tcp_pkg::SUM_W'(w_size)); // RULE5 RULE9
  wire err_b = in_packet & ~seg_first & (word != saved_b); // RULE17
  wire err_seq = (in_packet & seg_first) | (~in_packet & ~seg_first); // RULE18
  wire err_align = (align_code == tcp_pkg::ALIGN_RSVD); // RULE16
  wire err_event = take_b & (err_len | err_b | err_seq | err_align);

  // Phase that follows the data words
  // Pad counts widened to the phase counter
  wire [tcp_pkg::CNT_W-1:0] pad_cnt = tcp_pkg::CNT_W'(pad_n);
  wire [tcp_pkg::CNT_W-1:0] pad_cnt_b = tcp_pkg::CNT_W'(pad_calc);

  // Next state and counter
  // Empty phases are passed over so no cycle is lost between buffers
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      tcp_pkg::ST_CMD_A: begin
        if (take_a) begin
          next_state = tcp_pkg::ST_CMD_B;
        end
      end
      tcp_pkg::ST_CMD_B: begin
        if (take_b) begin
          if (skip_n != 3'h0) begin
            next_state = tcp_pkg::ST_SKIP; // RULE12
            next_cnt = tcp_pkg::CNT_W'(skip_n);
          end else if (data_n != '0) begin
            next_state = tcp_pkg::ST_DATA; // RULE10
            next_cnt = data_n;
          end else if (pad_calc != 3'h0) begin
            next_state = tcp_pkg::ST_PAD;
            next_cnt = pad_cnt_b;
          end else begin
            next_state = tcp_pkg::ST_CMD_A;
          end
        end
      end
      tcp_pkg::ST_SKIP: begin
        if (fifo_pop) begin
          next_cnt = cnt - 1'b1;
          if (last_word) begin
            if (data_n != '0) begin
              next_state = tcp_pkg::ST_DATA;
              next_cnt = data_n;
            end else if (pad_n != 3'h0) begin
              next_state = tcp_pkg::ST_PAD;
              next_cnt = pad_cnt;
            end else begin
              next_state = tcp_pkg::ST_CMD_A;
            end
          end
        end
      end
      tcp_pkg::ST_DATA: begin
        if (take_d) begin
          next_cnt = cnt - 1'b1;
          if (last_word) begin
            if (pad_n != 3'h0) begin
              next_state = tcp_pkg::ST_PAD;
              next_cnt = pad_cnt;
            end else begin
              next_state = tcp_pkg::ST_CMD_A;
            end
          end
        end
      end
      tcp_pkg::ST_PAD: begin
        if (fifo_pop) begin
          next_cnt = cnt - 1'b1; // RULE14
          if (last_word) begin
            next_state = tcp_pkg::ST_CMD_A;
          end
        end
      end
      default: begin
        next_state = tcp_pkg::ST_CMD_A;
        next_cnt = '0;
      end
    endcase
  end

  // State register
  // Counter holds the words left in the current phase
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= tcp_pkg::ST_CMD_A;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Capture first command word fields
  // Held until the next buffer's first command word
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_off <= '0;
      align_code <= tcp_pkg::ALIGN_4;
      seg_first <= 1'b0;
      seg_last <= 1'b0;
      buf_size <= '0;
    end else if (take_a) begin
      start_off <= w_off; // RULE1
      align_code <= w_align; // RULE16
      seg_first <= w_first; // RULE2
      seg_last <= w_last; // RULE3
      buf_size <= w_size; // RULE4
    end
  end

  // Packet tracking on the second command word
  // Only the opening segment's word is kept for the match check
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      saved_b <= '0;
      byte_sum <= '0;
      in_packet <= 1'b0;
      pad_n <= '0;
    end else if (take_b) begin
      saved_b <= seg_first ? word : saved_b; // RULE17
      byte_sum <= sum_new; // RULE5
      in_packet <= ~seg_last; // RULE2 RULE3
      pad_n <= pad_calc; // RULE4
    end
  end

  // Frame controls for the MAC, taken from the opening segment
  // Later segments must repeat them, so they are not reloaded
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pkt_tag <= '0;
      crc_append <= 1'b1;
      pad_disable <= 1'b0;
    end else if (take_b & seg_first) begin
      pkt_tag <= w_tag; // RULE6
      crc_append <= ~w_crc_off | w_pad_off; // RULE7 RULE8
      pad_disable <= w_pad_off; // RULE8
    end
  end

  // First-word markers for lanes and packet start
  // The packet mark survives a segment with no data words
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_pending <= 1'b0;
      word_first <= 1'b0;
    end else begin
      if (take_b) begin
        first_pending <= seg_first | first_pending;
        word_first <= 1'b1;
      end else if (take_d) begin
        first_pending <= 1'b0;
        word_first <= 1'b0;
      end
    end
  end

  // Output word register towards the MAC
  // A stalled word never changes until the MAC takes it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
      tx_byte_en <= '0;
      tx_first <= 1'b0;
      tx_last <= 1'b0;
    end else if (take_d) begin
      tx_valid <= 1'b1;
      tx_data <= word;
      tx_byte_en <= word_be; // RULE11 RULE13
      tx_first <= first_pending;
      tx_last <= seg_last & last_word;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // Sticky error flag; a new error wins over a clear
  // No resync: parsing goes on with the words as given
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      transmit_error_flag <= 1'b0;
    end else if (err_event) begin
      transmit_error_flag <= 1'b1; // RULE5 RULE17 RULE18
    end else if (error_clear) begin
      transmit_error_flag <= 1'b0;
    end
  end

  // Host back-pressure straight from the FIFO's registered flag
  // Copy only, so the host sees a flop output
  always_comb begin
    host_ready = fifo_in_ready;
  end
endmodule : tcp_parser

// [rtl/tcp_pkg.sv]
// Constants for the transmit command word parser.
// Assumes one clock domain; used by tcp_parser, which sizes tcp_fifo from it.
package tcp_pkg;
  // Data path widths
  localparam int WORD_W = 32;
  localparam int BE_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int SIZE_W = 11;
  localparam int SUM_W = 12;
  localparam int CNT_W = 10;

  // First command word fields
  localparam int A_OFF_HI = 20;
  localparam int A_OFF_LO = 16;
  localparam int A_ALIGN_HI = 25;
  localparam int A_ALIGN_LO = 24;
  localparam int A_FIRST_BIT = 13;
  localparam int A_LAST_BIT = 12;
  localparam int SIZE_HI = 10;

  // Second command word fields
  localparam int B_TAG_HI = 31;
  localparam int B_TAG_LO = 16;
  localparam int B_CRC_OFF_BIT = 13;
  localparam int B_PAD_OFF_BIT = 12;

  // End alignment codes
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [1:0] ALIGN_RSVD = 2'h3;

  // Alignment sizes in words, less one (used as masks)
  localparam logic [2:0] ALIGN_4_MASK = 3'h0;
  localparam logic [2:0] ALIGN_16_MASK = 3'h3;
  localparam logic [2:0] ALIGN_32_MASK = 3'h7;

  // Command words ahead of each buffer's data
  localparam logic [12:0] CMD_WORDS = 13'h0002;
  localparam logic [SUM_W-1:0] BYTE_ROUND = 12'h003;
  localparam logic [BE_W-1:0] BE_ALL = 4'hf;
  localparam logic [1:0] LANE_TOP = 2'h3;

  // Parser states
  typedef enum logic [2:0] {
    ST_CMD_A = 3'b000,
    ST_CMD_B = 3'b001,
    ST_SKIP = 3'b010,
    ST_DATA = 3'b011,
    ST_PAD = 3'b100
  } tcp_state_t;
endpackage : tcp_pkg

// [verif/tcp_host.sv]
// Host model: queues transmit buffers, offers one word at a time.
// Assumes host_ready from the parser; slow puts idle gaps in.
`timescale 1ns/100ps
module tcp_host (
  input wire logic ref_clk,
  input wire logic host_ready,
  input wire logic slow,
  output logic host_valid,
  output logic [31:0] host_data
);
  logic [31:0] q[$];
  logic took = 1'b0;
  logic gap = 1'b0;
  initial host_valid = 1'b0;
  initial host_data = 32'h0;
  // Acceptance at the sampling edge
  always @(posedge ref_clk) took <= host_valid & host_ready;
  // Word held until taken; a released line toggles
  always @(negedge ref_clk) begin
    if (took) void'(q.pop_front());
    if (took || !host_valid) begin
      gap = slow & ~gap;
      host_valid = q.size() > 0 && !gap;
      host_data = host_valid ? q[0] : ~host_data;
    end
  end
  // Command words with reserved bits zero
  function automatic logic [31:0] cmd_a(input logic [4:0] off, input logic [1:0] aln,
      input logic fs, input logic ls, input logic [10:0] sz);
    return {6'h0, aln, 3'h0, off, 2'h0, fs, ls, 1'b0, sz};
  endfunction : cmd_a
  function automatic logic [31:0] cmd_b(input logic [15:0] tag, input logic nocrc,
      input logic nopad, input logic [10:0] len);
    return {tag, 2'h0, nocrc, nopad, 1'b0, len};
  endfunction : cmd_b
  // Buffer: commands, skipped words, data, end padding
  task automatic send(input logic [31:0] a, input logic [31:0] b, input logic [7:0] base);
    int nd;
    int m;
    logic [31:0] w;
    nd = (a[17:16] + a[10:0] + 3) / 4;
    m = (a[25:24] == 2'h2) ? 7 : (a[25:24] == 2'h1) ? 3 : 0;
    q.push_back(a);
    q.push_back(b);
    for (int n = 0; n < a[20:18]; n++) q.push_back(32'hdeadbeef);
    for (int n = 0; n < 4 * nd; n++) begin
      w[8*(n%4) +: 8] = base + 8'(n);
      if (n % 4 == 3) q.push_back(w);
    end
    for (int n = 0; n < (-(2 + a[20:18] + nd) & m); n++) q.push_back(32'hbad0bad0);
  endtask : send
endmodule : tcp_host

// [verif/tcp_parser_checker.sv]
// Checker on the parser's top ports, bound below.
// Assumes one clock and the active-low reset.
`timescale 1ns/100ps
module tcp_parser_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic host_valid,
  input wire logic [31:0] host_data,
  input wire logic host_ready,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic [3:0] tx_byte_en,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic [15:0] pkt_tag,
  input wire logic crc_append,
  input wire logic pad_disable,
  input wire logic transmit_error_flag,
  input wire logic error_clear
);
  logic in_pkt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Packet left open by an accepted word
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) in_pkt <= 1'b0;
    else if (tx_valid && tx_ready) in_pkt <= !tx_last;
  end
  // Output words and flags
  hold_stable_a: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_data) && $stable(tx_byte_en) && $stable(tx_last))
    else $error("stalled word changed");
  lanes_used_a: assert property (tx_valid |-> tx_byte_en != 4'h0)
    else $error("word without bytes");
  lanes_joined_a: assert property (tx_valid |-> $onehot0(
    {1'b0, tx_byte_en} + ({1'b0, tx_byte_en} & (~{1'b0, tx_byte_en} + 5'h1))))
    else $error("lanes not contiguous");
  fcs_forced_a: assert property (pad_disable |-> crc_append)
    else $error("fcs off with padding off");
  err_sticky_a: assert property (transmit_error_flag && !error_clear |=>
    transmit_error_flag) else $error("error flag dropped");
  err_cleared_a: assert property ($fell(transmit_error_flag) |-> $past(error_clear))
    else $error("error flag fell unasked");
  fifo_full_a: assert property ($fell(host_ready) |-> $past(host_valid))
    else $error("ready fell without store");
  pkt_frame_a: assert property (@(posedge ref_clk)
    disable iff (!reset_n || transmit_error_flag) tx_valid |-> tx_first == !in_pkt)
    else $error("first mark misplaced");
endmodule : tcp_parser_checker

bind tcp_parser tcp_parser_checker i_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .host_valid(host_valid), .host_data(host_data), .host_ready(host_ready),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_byte_en(tx_byte_en), .tx_first(tx_first),
  .tx_last(tx_last), .tx_ready(tx_ready), .pkt_tag(pkt_tag), .crc_append(crc_append),
  .pad_disable(pad_disable), .transmit_error_flag(transmit_error_flag),
  .error_clear(error_clear));

// [verif/tx_command_word_parser_test.sv]
// Bench for the parser with host model and MAC sink.
// Assumes tcp_pkg, tcp_fifo, tcp_parser, tcp_host, checker.
`timescale 1ns/100ps
module tx_command_word_parser_test;
  logic ref_clk, reset_n, slow, host_valid, host_ready, tx_valid, tx_ready;
  logic tx_first, tx_last, crc_append, pad_disable, transmit_error_flag, error_clear;
  logic [31:0] host_data, tx_data;
  logic [3:0] tx_byte_en;
  logic [15:0] pkt_tag;
  logic [7:0] got[$], want[$];
  logic [1:0] fl[$];
  int n_errors = 0;
  int comparisons = 0;
  tcp_parser i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .host_valid(host_valid),
    .host_data(host_data), .host_ready(host_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_byte_en(tx_byte_en), .tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready),
    .pkt_tag(pkt_tag), .crc_append(crc_append), .pad_disable(pad_disable),
    .transmit_error_flag(transmit_error_flag), .error_clear(error_clear));
  tcp_host i_host (.ref_clk(ref_clk), .host_ready(host_ready), .slow(slow),
    .host_valid(host_valid), .host_data(host_data));
  // Clock
  always #4 ref_clk = ~ref_clk;
  // MAC sink keeps enabled bytes and end marks
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) begin
      for (int j = 0; j < 4; j++) if (tx_byte_en[j]) got.push_back(tx_data[8*j +: 8]);
      fl.push_back({tx_first, tx_last});
    end
  end
  task automatic final_report();
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic chk_stream(input int n_pkt);
    int n_first;
    int n_last;
    n_first = 0;
    n_last = 0;
    foreach (fl[i]) begin
      n_first += fl[i][1];
      n_last += fl[i][0];
    end
    chk("byte count", want.size(), got.size());
    foreach (want[i]) chk("byte", want[i], got[i]);
    chk("first mark", 2'h2, fl[0] & 2'h2);
    chk("last mark", 2'h1, fl[$] & 2'h1);
    chk("first marks", n_pkt, n_first);
    chk("last marks", n_pkt, n_last);
    got.delete();
    want.delete();
    fl.delete();
  endtask : chk_stream
  task automatic expect_bytes(input int off, input int sz, input logic [7:0] base);
    for (int i = 0; i < sz; i++) want.push_back(base + 8'(off % 4 + i));
  endtask : expect_bytes
  // Wait until host and output stay idle
  task automatic settle();
    int idle;
    idle = 0;
    for (int t = 0; t < 500 && idle < 12; t++) begin
      @(negedge ref_clk);
      idle = (i_host.q.size() == 0 && !tx_valid) ? idle + 1 : 0;
    end
    chk("drain", 12, idle);
    if (idle < 12) final_report();
  endtask : settle
  task automatic do_reset();
    reset_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk("fcs at reset", 1, crc_append);
    chk("error at reset", 0, transmit_error_flag);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask : do_reset
  task automatic expect_err();
    settle();
    chk("error set", 1, transmit_error_flag);
    error_clear = 1'b1;
    @(negedge ref_clk);
    error_clear = 1'b0;
    @(negedge ref_clk);
    chk("error cleared", 0, transmit_error_flag);
  endtask : expect_err
  task automatic put4(input logic fs, input logic ls, input logic [15:0] tg,
      input logic [10:0] len);
    i_host.send(i_host.cmd_a(5'h0, 2'h0, fs, ls, 11'h4), i_host.cmd_b(tg, 1'b0, 1'b0, len),
      8'h0);
  endtask : put4
  // Every lane code, word skips, each alignment, fcs codes
  task automatic sc_offsets();
    logic [4:0] off;
    logic [10:0] sz;
    for (int k = 0; k < 5; k++) begin
      off = (k == 4) ? 5'h1f : 5'(k * 9);
      sz = 11'(3 + k * 5);
      i_host.send(i_host.cmd_a(off, 2'(k % 3), 1'b1, 1'b1, sz),
        i_host.cmd_b(16'(k) + 16'ha5a0, k[0], k == 3, sz), 8'(k * 32));
      expect_bytes(off, sz, 8'(k * 32));
      settle();
      chk("fcs", !k[0] || k == 3, crc_append);
      chk("pad off", k == 3, pad_disable);
      chk("tag", 16'(k) + 16'ha5a0, pkt_tag);
    end
    chk_stream(5);
    chk("error", 0, transmit_error_flag);
  endtask : sc_offsets
  // Two segments, MAC stalled until the FIFO refuses
  task automatic sc_multi();
    logic [31:0] b;
    int t;
    b = i_host.cmd_b(16'h0bee, 1'b1, 1'b1, 11'hc);
    tx_ready = 1'b0;
    slow = 1'b1;
    i_host.send(i_host.cmd_a(5'h3, 2'h1, 1'b1, 1'b0, 11'h5), b, 8'h40);
    i_host.send(i_host.cmd_a(5'h0, 2'h2, 1'b0, 1'b1, 11'h7), b, 8'h80);
    expect_bytes(3, 5, 8'h40);
    expect_bytes(0, 7, 8'h80);
    t = 0;
    while (host_ready !== 1'b0 && t < 60) begin
      @(negedge ref_clk);
      t++;
    end
    chk("fifo full", 0, host_ready);
    tx_ready = 1'b1;
    settle();
    slow = 1'b0;
    chk_stream(1);
    chk("fcs forced", 1, crc_append);
    chk("pad off", 1, pad_disable);
    chk("tag", 16'h0bee, pkt_tag);
    chk("error", 0, transmit_error_flag);
  endtask : sc_multi
  // Each framing fault raises the sticky error
  task automatic sc_errors();
    put4(1'b1, 1'b1, 16'h1, 11'h5);
    expect_err();
    put4(1'b1, 1'b0, 16'h1, 11'h8);
    put4(1'b0, 1'b1, 16'h2, 11'h8);
    expect_err();
    put4(1'b0, 1'b1, 16'h3, 11'h4);
    expect_err();
    put4(1'b1, 1'b0, 16'h4, 11'h4);
    put4(1'b1, 1'b1, 16'h4, 11'h4);
    expect_err();
    i_host.send(i_host.cmd_a(5'h0, 2'h3, 1'b1, 1'b1, 11'h4),
      i_host.cmd_b(16'h5, 1'b0, 1'b0, 11'h4), 8'h0);
    expect_err();
    got.delete();
    fl.delete();
    do_reset();
  endtask : sc_errors
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    tx_ready = 1'b1;
    error_clear = 1'b0;
    slow = 1'b0;
    do_reset();
    sc_offsets();
    sc_multi();
    sc_errors();
    sc_offsets();
    final_report();
  end
endmodule : tx_command_word_parser_test
